/* pmsa_pkg.sv */
// Package of constants and types for the PHY status and ability registers
package pmsa_pkg;

   // ---------------------------------------------------------------
   // Register addresses inside each PHY
   // ---------------------------------------------------------------
   localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
   localparam logic [4:0] REG_ID_UPPER = 5'h02;
   localparam logic [4:0] REG_ID_LOWER = 5'h03;
   localparam logic [4:0] REG_AN_ADVERT = 5'h04;
   localparam logic [4:0] REG_PARTNER = 5'h05;

   // ---------------------------------------------------------------
   // Default management addresses of the two PHYs
   // ---------------------------------------------------------------
   localparam logic [4:0] PHY_ADDR_PORT1_RST = 5'h01;
   localparam logic [4:0] PHY_ADDR_PORT2_RST = 5'h02;

   // ---------------------------------------------------------------
   // Field positions and fixed values
   // ---------------------------------------------------------------
   localparam int STAT_AN_DONE_BIT = 5;
   localparam int STAT_FAULT_BIT = 4;
   localparam int STAT_AN_ABLE_BIT = 3;
   localparam int STAT_LINK_BIT = 2;
   localparam logic [3:0] STAT_SPEED_CAPS = 4'hf;
   localparam int STAT_CAPS_LSB = 11;
   localparam int ABIL_PAUSE_BIT = 10;
   localparam int ABIL_LSB = 5;
   localparam logic [4:0] ADV_SELECTOR = 5'h01;
   localparam logic [4:0] ADV_ABIL_RST = 5'h1f;
   localparam logic [4:0] PARTNER_ABIL_RST = 5'h00;

   // ---------------------------------------------------------------
   // Management frame fields
   // ---------------------------------------------------------------
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [5:0] PREAMBLE_BITS = 6'h20;
   localparam logic [4:0] ADDR_LAST_BIT = 5'h09;
   localparam logic [4:0] DATA_LAST_BIT = 5'h0f;
   localparam logic [4:0] READ_RELEASE = 5'h10;

   // Frame phases as seen by the responding PHY
   typedef enum logic [2:0] {
      ST_PREAMBLE,
      ST_START,
      ST_OPCODE,
      ST_ADDRESS,
      ST_TURN,
      ST_READ_DATA,
      ST_WRITE_DATA
   } pmsa_state_t;

endpackage : pmsa_pkg

/* pmsa_phy_regs.sv */
// Management register file of the two PHYs behind a sampled MDC/MDIO port
`timescale 1ns/100ps

// What this block does
// [RULE_01] Status bit 15 always reads zero: no four-pair 100 Mbps ability.
// [RULE_02] Status bits 14 to 11 always read one: all four speed modes.
// [RULE_03] Status bit 5 shows negotiation done, bit 2 link up; both reset zero.
// [RULE_04] Status bit 4 shows a far-end fault on the port; resets zero.
// [RULE_05] Status bit 3 follows the port's negotiation enable, default one.
// [RULE_06] Status bit 0 always reads zero: no extended register set.
// [RULE_07] Address 2 returns the fixed upper identifier word; writes ignored.
// [RULE_08] Address 3 returns the fixed lower identifier word; writes ignored.
// [RULE_09] Advertisement bit 10, pause, writable, resets one, mirrors port control.
// [RULE_10] Advertisement bit 8, 100 full duplex, writable, resets one.
// [RULE_11] Advertisement bit 7, 100 half duplex, writable, resets one.
// [RULE_12] Advertisement bit 6, 10 full duplex, writable, resets one.
// [RULE_13] Advertisement bit 5, 10 half duplex, writable, resets one.
// [RULE_14] Partner bit 10 shows received pause ability, read only, resets zero.
// [RULE_15] Partner bit 8 shows partner 100 full ability, read only, resets zero.
// [RULE_16] Partner bit 7 shows partner 100 half ability, read only, resets zero.
// [RULE_17] Partner bit 6 shows partner 10 full ability, read only, resets zero.
// [RULE_18] Partner bit 5 shows partner 10 half ability, read only, resets zero.
// [RULE_19] Selector field reads fixed 802.3 code; partner bits 4 to 0 zero.
// [RULE_20] Reserved and unsupported bits read zero and ignore writes.
// [RULE_21] Port 1 answers address 1, port 2 address 2; both reprogrammable.
module pmsa_phy_regs #(
   parameter logic [15:0] ID_UPPER = 16'h1234, // Arbitrary value
   parameter logic [15:0] ID_LOWER = 16'h5678, // Arbitrary value
   parameter int PREAMBLE_LEN = 32
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Management link pins
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   // Management address programming
   input wire logic addr_override,
   input wire logic [4:0] phy_addr_port1,
   input wire logic [4:0] phy_addr_port2,
   // Live per-port status, index 0 is port 1
   input wire logic [1:0] link_up,
   input wire logic [1:0] autoneg_done_flag,
   input wire logic [1:0] far_end_fault,
   input wire logic [1:0] autoneg_enable,
   input wire logic [9:0] partner_abil,
   // Port control side of the advertisement bits
   input wire logic [1:0] ctl_adv_we,
   input wire logic [9:0] ctl_adv_wdata,
   output logic [9:0] adv_abil
);

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   if (PREAMBLE_LEN < 1 || PREAMBLE_LEN > 32) begin : g_bad_pre
      $error("PREAMBLE_LEN must lie between 1 and 32");
   end

   localparam logic [5:0] PRE_NEED = 6'(PREAMBLE_LEN);

   // ---------------------------------------------------------------
   // Pin synchronisers and clock edge finder
   // ---------------------------------------------------------------
   logic mdc_s1_reg, mdc_s2_reg, mdc_prev_reg;
   logic mdio_s1_reg, mdio_s2_reg;
   logic mdc_rise;

   // Two stages on each pin; only the second stage is looked at
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mdc_s1_reg <= 1'b0;
         mdc_s2_reg <= 1'b0;
         mdc_prev_reg <= 1'b0;
         mdio_s1_reg <= 1'b1;
         mdio_s2_reg <= 1'b1;
      end else begin
         mdc_s1_reg <= mdc;
         mdc_s2_reg <= mdc_s1_reg;
         mdc_prev_reg <= mdc_s2_reg;
         mdio_s1_reg <= mdio_in;
         mdio_s2_reg <= mdio_s1_reg;
      end
   end

   // Data and clock share equal latency, so sampling stays aligned
   assign mdc_rise = mdc_s2_reg & ~mdc_prev_reg;

   // ---------------------------------------------------------------
   // Snapshot of live port status
   // ---------------------------------------------------------------
   logic [1:0] link_reg, an_done_reg, fault_reg, an_en_reg;
   logic [9:0] partner_reg;

   // [RULE_03] status capture from reset
   // Registered so every live bit starts from its documented reset value
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         link_reg <= 2'h0;
         an_done_reg <= 2'h0;
         fault_reg <= 2'h0;
         an_en_reg <= 2'h3;
      end else begin
         link_reg <= link_up;
         an_done_reg <= autoneg_done_flag;
         fault_reg <= far_end_fault;
         an_en_reg <= autoneg_enable;
      end
   end

   // [RULE_14] partner ability capture
   // Bits 4:0 of each port half carry pause, 100F, 100H, 10F, 10H
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         partner_reg <= {pmsa_pkg::PARTNER_ABIL_RST,
                         pmsa_pkg::PARTNER_ABIL_RST};
      end else begin
         partner_reg <= partner_abil;
      end
   end

   // ---------------------------------------------------------------
   // Frame decoder state
   // ---------------------------------------------------------------
   pmsa_pkg::pmsa_state_t state_reg;
   logic [5:0] pre_cnt_reg;
   logic [4:0] bit_cnt_reg;
   logic [1:0] op_reg;
   logic [8:0] addr_sr_reg;
   logic is_read_reg;
   logic port_sel_reg;
   logic [4:0] reg_sel_reg;
   logic [15:0] rd_sr_reg;
   logic [14:0] wr_sr_reg;
   logic [9:0] adv_reg;
   logic [4:0] addr1, addr2;
   logic [9:0] addr_full;
   logic hit1, hit2, reg_ok, op_ok;
   logic wr_commit;
   logic [15:0] wr_word;

   // [RULE_21] address match per port
   assign addr1 = addr_override ? phy_addr_port1 :
                  pmsa_pkg::PHY_ADDR_PORT1_RST;
   assign addr2 = addr_override ? phy_addr_port2 :
                  pmsa_pkg::PHY_ADDR_PORT2_RST;
   assign addr_full = {addr_sr_reg, mdio_s2_reg};
   assign hit1 = (addr_full[9:5] == addr1);
   assign hit2 = (addr_full[9:5] == addr2);
   // Other register numbers belong to neighbouring logic; stay silent
   assign reg_ok = (addr_full[4:0] >= pmsa_pkg::REG_BASIC_STATUS) &&
                   (addr_full[4:0] <= pmsa_pkg::REG_PARTNER);
   assign op_ok = (op_reg == pmsa_pkg::OP_READ) ||
                  (op_reg == pmsa_pkg::OP_WRITE);
   assign wr_word = {wr_sr_reg, mdio_s2_reg};
   assign wr_commit = mdc_rise && (state_reg == pmsa_pkg::ST_WRITE_DATA) &&
                      (bit_cnt_reg == pmsa_pkg::DATA_LAST_BIT);

   // ---------------------------------------------------------------
   // Read word assembly
   // ---------------------------------------------------------------
   // Reserved bit just above the four speed ability bits in a word
   localparam int ABIL_HI = pmsa_pkg::ABIL_LSB + 4;
   function automatic logic [15:0] read_word(input logic p,
                                             input logic [4:0] ra);
      logic [15:0] w;
      w = 16'h0000;
      case (ra)
         pmsa_pkg::REG_BASIC_STATUS: begin
            // [RULE_01] bit 15 left zero
            // [RULE_02] fixed speed abilities
            w[pmsa_pkg::STAT_CAPS_LSB +: 4] = pmsa_pkg::STAT_SPEED_CAPS;
            // [RULE_03] done and link bits
            w[pmsa_pkg::STAT_AN_DONE_BIT] = an_done_reg[p];
            w[pmsa_pkg::STAT_LINK_BIT] = link_reg[p];
            // [RULE_04] far-end fault bit
            w[pmsa_pkg::STAT_FAULT_BIT] = fault_reg[p];
            // [RULE_05] follows negotiation enable
            w[pmsa_pkg::STAT_AN_ABLE_BIT] = an_en_reg[p];
            // [RULE_06] bit 0 left zero
         end
         // [RULE_07] upper identifier
         pmsa_pkg::REG_ID_UPPER: w = ID_UPPER;
         // [RULE_08] lower identifier
         pmsa_pkg::REG_ID_LOWER: w = ID_LOWER;
         pmsa_pkg::REG_AN_ADVERT: begin
            w[ABIL_HI:pmsa_pkg::ABIL_LSB + 2] = p ? adv_reg[9:7] :
                                                    adv_reg[4:2];
            w[pmsa_pkg::ABIL_LSB + 1 -: 2] = p ? adv_reg[6:5] :
                                                 adv_reg[1:0];
            // [RULE_19] fixed selector
            w[4:0] = pmsa_pkg::ADV_SELECTOR;
         end
         pmsa_pkg::REG_PARTNER: begin
            // [RULE_15] partner speeds with pause above
            // [RULE_16] partner 100 half from capture
            // [RULE_17] partner 10 full from capture
            // [RULE_18] partner 10 half from capture
            w[ABIL_HI:pmsa_pkg::ABIL_LSB + 2] = p ? partner_reg[9:7] :
                                                    partner_reg[4:2];
            w[pmsa_pkg::ABIL_LSB + 1 -: 2] = p ? partner_reg[6:5] :
                                                 partner_reg[1:0];
         end
         default: w = 16'h0000;
      endcase
      // [RULE_20] reserved bits 9 and 15:11 of ability words
      if (ra == pmsa_pkg::REG_AN_ADVERT || ra == pmsa_pkg::REG_PARTNER) begin
         w[9] = 1'b0;
         w[15:11] = 5'h00;
         w[pmsa_pkg::ABIL_PAUSE_BIT] = (ra == pmsa_pkg::REG_AN_ADVERT) ?
            (p ? adv_reg[9] : adv_reg[4]) :
            (p ? partner_reg[9] : partner_reg[4]);
         w[8:5] = (ra == pmsa_pkg::REG_AN_ADVERT) ?
            (p ? adv_reg[8:5] : adv_reg[3:0]) :
            (p ? partner_reg[8:5] : partner_reg[3:0]);
      end
      return w;
   endfunction : read_word

   // ---------------------------------------------------------------
   // Frame sequencer, advanced on each sampled MDC rise
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg <= pmsa_pkg::ST_PREAMBLE;
         pre_cnt_reg <= 6'h00;
         bit_cnt_reg <= 5'h00;
         op_reg <= 2'h0;
         addr_sr_reg <= 9'h000;
         is_read_reg <= 1'b0;
         port_sel_reg <= 1'b0;
         reg_sel_reg <= 5'h00;
      end else if (mdc_rise) begin
         case (state_reg)
            pmsa_pkg::ST_PREAMBLE: begin
               // A zero after enough ones is the first start bit
               if (mdio_s2_reg) begin
                  if (pre_cnt_reg < PRE_NEED) begin
                     pre_cnt_reg <= pre_cnt_reg + 6'h01;
                  end
               end else begin
                  pre_cnt_reg <= 6'h00;
                  if (pre_cnt_reg >= PRE_NEED) begin
                     state_reg <= pmsa_pkg::ST_START;
                  end
               end
            end
            pmsa_pkg::ST_START: begin
               bit_cnt_reg <= 5'h00;
               state_reg <= mdio_s2_reg ? pmsa_pkg::ST_OPCODE :
                                          pmsa_pkg::ST_PREAMBLE;
            end
            pmsa_pkg::ST_OPCODE: begin
               op_reg <= {op_reg[0], mdio_s2_reg};
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
               if (bit_cnt_reg == 5'h01) begin
                  bit_cnt_reg <= 5'h00;
                  state_reg <= pmsa_pkg::ST_ADDRESS;
               end
            end
            pmsa_pkg::ST_ADDRESS: begin
               addr_sr_reg <= addr_full[8:0];
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
               if (bit_cnt_reg == pmsa_pkg::ADDR_LAST_BIT) begin
                  bit_cnt_reg <= 5'h00;
                  is_read_reg <= (op_reg == pmsa_pkg::OP_READ);
                  port_sel_reg <= ~hit1;
                  reg_sel_reg <= addr_full[4:0];
                  // Frames for other PHYs are ignored until a new preamble
                  state_reg <= ((hit1 || hit2) && reg_ok && op_ok) ?
                     pmsa_pkg::ST_TURN : pmsa_pkg::ST_PREAMBLE;
               end
            end
            pmsa_pkg::ST_TURN: begin
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
               if (is_read_reg) begin
                  bit_cnt_reg <= 5'h00;
                  state_reg <= pmsa_pkg::ST_READ_DATA;
               end else if (bit_cnt_reg == 5'h01) begin
                  bit_cnt_reg <= 5'h00;
                  state_reg <= pmsa_pkg::ST_WRITE_DATA;
               end
            end
            pmsa_pkg::ST_READ_DATA: begin
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
               if (bit_cnt_reg == pmsa_pkg::READ_RELEASE) begin
                  state_reg <= pmsa_pkg::ST_PREAMBLE;
               end
            end
            pmsa_pkg::ST_WRITE_DATA: begin
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
               if (bit_cnt_reg == pmsa_pkg::DATA_LAST_BIT) begin
                  state_reg <= pmsa_pkg::ST_PREAMBLE;
               end
            end
            default: state_reg <= pmsa_pkg::ST_PREAMBLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Read shifter and pin drive
   // ---------------------------------------------------------------
   // Drive changes three system clocks after MDC rises, leaving most of an MDC period of setup
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rd_sr_reg <= 16'h0000;
         mdio_out <= 1'b0;
         mdio_oe <= 1'b0;
      end else if (mdc_rise) begin
         if (state_reg == pmsa_pkg::ST_TURN && is_read_reg) begin
            // Second turnaround bit: drive zero, freeze the word now
            mdio_oe <= 1'b1;
            mdio_out <= 1'b0;
            rd_sr_reg <= read_word(port_sel_reg, reg_sel_reg);
         end else if (state_reg == pmsa_pkg::ST_READ_DATA &&
                      bit_cnt_reg != pmsa_pkg::READ_RELEASE) begin
            mdio_out <= rd_sr_reg[15];
            rd_sr_reg <= {rd_sr_reg[14:0], 1'b0};
         end else begin
            mdio_oe <= 1'b0;
            mdio_out <= 1'b0;
         end
      end
   end

   // Write data collected most significant bit first
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_sr_reg <= 15'h0000;
      end else if (mdc_rise && state_reg == pmsa_pkg::ST_WRITE_DATA) begin
         wr_sr_reg <= wr_word[14:0];
      end
   end

   // ---------------------------------------------------------------
   // Advertisement bits
   // ---------------------------------------------------------------
   // [RULE_09] shared with port control
   // Management write wins a same-cycle clash with the port control side
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         // [RULE_10] all ability bits reset to one
         adv_reg <= {pmsa_pkg::ADV_ABIL_RST, pmsa_pkg::ADV_ABIL_RST};
      end else begin
         for (int i = 0; i < 2; i++) begin
            // [RULE_11] write of 100 half and the rest
            if (wr_commit && reg_sel_reg == pmsa_pkg::REG_AN_ADVERT &&
                port_sel_reg == 1'(i)) begin
               // [RULE_12] bits 10 and 8:5 taken; others dropped
               adv_reg[i*5 +: 5] <= {wr_word[pmsa_pkg::ABIL_PAUSE_BIT],
                                     wr_word[8:5]};
            end else if (ctl_adv_we[i]) begin
               // [RULE_13] port control mirror path
               adv_reg[i*5 +: 5] <= ctl_adv_wdata[i*5 +: 5];
            end
         end
      end
   end

   // Advertised abilities go to the negotiation logic of each port
   assign adv_abil = adv_reg;

endmodule : pmsa_phy_regs

/* pmsa_phy_regs_checker.sv */
// Port-level checker for the PHY status and ability register block
`timescale 1ns/100ps
module pmsa_phy_regs_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Management link pins
   input wire logic mdc,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   // Advertisement control side
   input wire logic [1:0] ctl_adv_we,
   input wire logic [9:0] ctl_adv_wdata,
   input wire logic [9:0] adv_abil
);
   logic mdc_q;
   logic [5:0] rise_cnt;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // Counts mdc rises seen while the block drives the line
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mdc_q <= 1'b0;
         rise_cnt <= 6'h00;
      end else begin
         mdc_q <= mdc;
         if (!mdio_oe) begin
            rise_cnt <= 6'h00;
         end else if (mdc && !mdc_q) begin
            rise_cnt <= rise_cnt + 6'h01;
         end
      end
   end

   adv_rst_a: assert property ($past(rst) |-> adv_abil == 10'h3ff)
      else $error("advertisement bits not all set after reset");
   ctl_port1_a: assert property (ctl_adv_we[0] |=>
      adv_abil[4:0] == $past(ctl_adv_wdata[4:0]))
      else $error("port 1 control write not mirrored");
   ctl_port2_a: assert property (ctl_adv_we[1] |=>
      adv_abil[9:5] == $past(ctl_adv_wdata[9:5]))
      else $error("port 2 control write not mirrored");
   read_stable_a: assert property (mdio_oe && $past(mdio_oe) &&
      $past(ctl_adv_we) == 2'b00 |-> $stable(adv_abil))
      else $error("advertisement changed during a read");
   out_idle_a: assert property (!mdio_oe |-> !mdio_out)
      else $error("data line driven high while released");
   out_hold_a: assert property (mdio_oe && $changed(mdio_out) |=>
      $stable(mdio_out) [*3])
      else $error("read data bit did not stand");
   // Turnaround bit plus sixteen data bits
   oe_span_a: assert property ($fell(mdio_oe) |-> rise_cnt == 6'd17)
      else $error("drive window not seventeen clock rises");
   ta_zero_a: assert property ($rose(mdio_oe) |-> !mdio_out [*4])
      else $error("turnaround bit not driven low");
   oe_rst_a: assert property ($past(rst) |-> !mdio_oe)
      else $error("line driven right after reset");
endmodule : pmsa_phy_regs_checker

bind pmsa_phy_regs pmsa_phy_regs_checker i_pmsa_phy_regs_checker (
   .clk_sys(clk_sys), .rst(rst), .mdc(mdc), .mdio_out(mdio_out),
   .mdio_oe(mdio_oe), .ctl_adv_we(ctl_adv_we),
   .ctl_adv_wdata(ctl_adv_wdata), .adv_abil(adv_abil));

/* pmsa_station_model.sv */
// Management station model driving mdc and the shared data line
`timescale 1ns/100ps
module pmsa_station_model (
   // Clock
   input wire logic clk_sys,
   // Block side of the data line
   input wire logic dut_out,
   input wire logic dut_oe,
   // Station pins
   output logic mdc,
   output logic mdio_in
);
   logic drv_oe;
   logic drv_val;

   // Pull-up wins when nobody drives the line
   assign mdio_in = dut_oe ? dut_out : (drv_oe ? drv_val : 1'b1);

   // Clock stands low between frames
   initial begin
      mdc = 1'b0;
      drv_oe = 1'b0;
      drv_val = 1'b0;
   end

   // One 200 ns bit: set data while low, sample at the rise
   task automatic clk_bit(input logic oe, input logic b, output logic s);
      drv_oe = oe;
      drv_val = b;
      repeat (4) @(negedge clk_sys);
      s = mdio_in;
      mdc = 1'b1;
      repeat (4) @(negedge clk_sys);
      mdc = 1'b0;
   endtask : clk_bit

   // Full frame with preamble; read releases the line after the address
   task automatic frame(input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] ra, input logic [15:0] wd,
      output logic [15:0] rd, output logic ta);
      logic [13:0] hdr;
      logic s;
      int i;
      hdr = {2'b01, op, phy, ra};
      rd = 16'h0000;
      ta = 1'b1;
      for (i = 0; i < 32; i++) clk_bit(1'b1, 1'b1, s);
      for (i = 13; i >= 0; i--) clk_bit(1'b1, hdr[i], s);
      if (op == pmsa_pkg::OP_READ) begin
         clk_bit(1'b0, 1'b0, s);
         clk_bit(1'b0, 1'b0, ta);
         for (i = 15; i >= 0; i--) begin
            clk_bit(1'b0, 1'b0, s);
            rd[i] = s;
         end
      end else begin
         clk_bit(1'b1, 1'b1, s);
         clk_bit(1'b1, 1'b0, s);
         for (i = 15; i >= 0; i--) clk_bit(1'b1, wd[i], s);
      end
      drv_oe = 1'b0;
      repeat (8) @(negedge clk_sys);
   endtask : frame
endmodule : pmsa_station_model

/* testbench.sv */
// Self-checking bench for the PHY status and ability registers
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
   localparam logic [15:0] ID_UP = 16'h3c5a; // Arbitrary value
   localparam logic [15:0] ID_LO = 16'h0f96; // Arbitrary value
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic mdc, mdio_in, mdio_out, mdio_oe;
   logic addr_override = 1'b0;
   logic [4:0] phy_addr_port1 = 5'h07;
   logic [4:0] phy_addr_port2 = 5'h1d;
   logic [1:0] link_up = 2'b00, autoneg_done_flag = 2'b00;
   logic [1:0] far_end_fault = 2'b00, autoneg_enable = 2'b11;
   logic [9:0] partner_abil = 10'h000;
   logic [1:0] ctl_adv_we = 2'b00;
   logic [9:0] ctl_adv_wdata = 10'h000;
   logic [9:0] adv_abil;
   int miscompares = 0;
   int n_tests = 0;

   // 40 MHz system clock
   always #12.5 clk_sys = ~clk_sys;

   pmsa_phy_regs #(.ID_UPPER(ID_UP), .ID_LOWER(ID_LO)) i_pmsa_phy_regs (
      .clk_sys(clk_sys), .rst(rst), .mdc(mdc), .mdio_in(mdio_in),
      .mdio_out(mdio_out), .mdio_oe(mdio_oe), .addr_override(addr_override),
      .phy_addr_port1(phy_addr_port1), .phy_addr_port2(phy_addr_port2),
      .link_up(link_up), .autoneg_done_flag(autoneg_done_flag),
      .far_end_fault(far_end_fault), .autoneg_enable(autoneg_enable),
      .partner_abil(partner_abil), .ctl_adv_we(ctl_adv_we),
      .ctl_adv_wdata(ctl_adv_wdata), .adv_abil(adv_abil));

   pmsa_station_model i_pmsa_station_model (.clk_sys(clk_sys),
      .dut_out(mdio_out), .dut_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in));

   // Ability field as it sits in the advertisement and partner words
   function automatic logic [15:0] abil_word(input logic [4:0] a);
      return {5'h00, a[4], 1'b0, a[3:0], 5'h00};
   endfunction : abil_word

   task automatic rd_chk(input logic [4:0] phy, input logic [4:0] ra,
      input logic [15:0] exp);
      logic [15:0] d;
      logic ta;
      i_pmsa_station_model.frame(pmsa_pkg::OP_READ, phy, ra, 16'h0, d, ta);
      `CHK("turnaround", 1'b0, ta);
      `CHK("read word", exp, d);
   endtask : rd_chk

   task automatic wr(input logic [4:0] phy, input logic [4:0] ra,
      input logic [15:0] wd);
      logic [15:0] d;
      logic ta;
      i_pmsa_station_model.frame(pmsa_pkg::OP_WRITE, phy, ra, wd, d, ta);
   endtask : wr

   task automatic t_defaults;
      `CHK("adv pins", 10'h3ff, adv_abil);
      rd_chk(5'h01, 5'h01, 16'h7808);
      rd_chk(5'h02, 5'h01, 16'h7808);
      rd_chk(5'h01, 5'h02, ID_UP);
      rd_chk(5'h02, 5'h03, ID_LO);
      rd_chk(5'h02, 5'h04, 16'h05e1);
      rd_chk(5'h01, 5'h05, 16'h0000);
      $display("t_defaults done");
   endtask : t_defaults

   task automatic t_status;
      link_up = 2'b01;
      autoneg_done_flag = 2'b01;
      far_end_fault = 2'b10;
      autoneg_enable = 2'b10;
      partner_abil = {5'h0a, 5'h15};
      rd_chk(5'h01, 5'h01, 16'h7824);
      rd_chk(5'h02, 5'h01, 16'h7818);
      rd_chk(5'h01, 5'h05, abil_word(5'h15));
      rd_chk(5'h02, 5'h05, abil_word(5'h0a));
      autoneg_enable = 2'b00;
      rd_chk(5'h02, 5'h01, 16'h7810);
      $display("t_status done");
   endtask : t_status

   task automatic t_adv_write;
      wr(5'h01, 5'h04, 16'hffff);
      rd_chk(5'h01, 5'h04, 16'h05e1);
      wr(5'h01, 5'h04, 16'h0000);
      rd_chk(5'h01, 5'h04, 16'h0001);
      `CHK("adv port1 clear", 5'h00, adv_abil[4:0]);
      `CHK("adv port2 kept", 5'h1f, adv_abil[9:5]);
      wr(5'h01, 5'h04, 16'h0520);
      rd_chk(5'h01, 5'h04, 16'h0521);
      `CHK("adv port1 mix", 5'h19, adv_abil[4:0]);
      $display("t_adv_write done");
   endtask : t_adv_write

   task automatic t_ro_write;
      wr(5'h01, 5'h02, 16'h0000);
      wr(5'h02, 5'h03, 16'hffff);
      wr(5'h01, 5'h05, 16'hffff);
      wr(5'h02, 5'h01, 16'h0000);
      rd_chk(5'h01, 5'h02, ID_UP);
      rd_chk(5'h02, 5'h03, ID_LO);
      rd_chk(5'h01, 5'h05, abil_word(5'h15));
      rd_chk(5'h02, 5'h01, 16'h7810);
      $display("t_ro_write done");
   endtask : t_ro_write

   task automatic t_ctl;
      ctl_adv_we = 2'b10;
      ctl_adv_wdata = {5'h0a, 5'h00};
      @(negedge clk_sys);
      ctl_adv_we = 2'b00;
      `CHK("ctl port2", 5'h0a, adv_abil[9:5]);
      `CHK("ctl port1 kept", 5'h19, adv_abil[4:0]);
      rd_chk(5'h02, 5'h04, abil_word(5'h0a) | 16'h0001);
      // Port 1 mirror path, port 2 must hold
      ctl_adv_we = 2'b01;
      ctl_adv_wdata = {5'h00, 5'h06};
      @(negedge clk_sys);
      ctl_adv_we = 2'b00;
      `CHK("ctl port1", 5'h06, adv_abil[4:0]);
      `CHK("ctl port2 kept", 5'h0a, adv_abil[9:5]);
      rd_chk(5'h01, 5'h04, abil_word(5'h06) | 16'h0001);
      $display("t_ctl done");
   endtask : t_ctl

   task automatic t_addr;
      logic [15:0] d;
      logic ta;
      addr_override = 1'b1;
      rd_chk(5'h07, 5'h02, ID_UP);
      rd_chk(5'h1d, 5'h03, ID_LO);
      i_pmsa_station_model.frame(pmsa_pkg::OP_READ, 5'h01, 5'h02, 16'h0,
         d, ta);
      `CHK("old address ta", 1'b1, ta);
      `CHK("old address word", 16'hffff, d);
      i_pmsa_station_model.frame(pmsa_pkg::OP_READ, 5'h07, 5'h06, 16'h0,
         d, ta);
      `CHK("unmapped word", 16'hffff, d);
      addr_override = 1'b0;
      rd_chk(5'h01, 5'h02, ID_UP);
      $display("t_addr done");
   endtask : t_addr

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report

   // Main sequence, inputs change on falling edges
   initial begin
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      repeat (2) @(negedge clk_sys);
      t_defaults();
      t_status();
      t_adv_write();
      t_ro_write();
      t_ctl();
      t_addr();
      final_report();
   end

   // About 32 frames of 13 us each; cut a hang well beyond that
   initial begin
      #1000000;
      miscompares++;
      final_report();
   end
endmodule : testbench
